// ---- core/cset_pkg.sv ----
package cset_pkg;
    // ----------------------------------------
    // Register offsets, byte addresses
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COMPARE = 8'h04;
    localparam logic [7:0] OFS_TIMER = 8'h08;
    localparam logic [7:0] OFS_STATUS = 8'h0C;
    localparam logic [7:0] OFS_MASK = 8'h10;

    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam int MODE_LSB = 0;
    localparam int TIMER_EN_BIT = 4;
    localparam int FLAG_MATCH = 0;
    localparam int FLAG_OVF = 1;
    localparam int NUM_FLAGS = 2;
    localparam logic [15:0] COMPARE_RST = 16'hFFFF;
    localparam logic [15:0] TIMER_RST = 16'h0000;
    localparam logic [1:0] MASK_RST = 2'h0;

    // ----------------------------------------
    // Compare mode codes
    // ----------------------------------------
    typedef logic [3:0] cset_mode_t;
    localparam cset_mode_t MODE_OFF = 4'h0;
    localparam cset_mode_t MODE_TOGGLE = 4'h2;
    localparam cset_mode_t MODE_SET = 4'h8;
    localparam cset_mode_t MODE_CLEAR = 4'h9;
    localparam cset_mode_t MODE_SWINT = 4'hA;
    localparam cset_mode_t MODE_TRIGGER = 4'hB;

    typedef struct packed {
        logic timer_en;
        cset_mode_t mode;
    } cset_ctrl_s;

    localparam cset_ctrl_s CTRL_RST = '{timer_en: 1'b0, mode: MODE_OFF};

    typedef struct packed {
        logic ovf;
        logic match;
    } cset_flags_s;
endpackage

// ---- core/cset_irq.sv ----
`timescale 1ns/100ps
module cset_irq (
    input wire logic clk_sys,
    input wire logic reset,
    input wire cset_pkg::cset_flags_s set_ev,
    input wire logic clr_we,
    input wire cset_pkg::cset_flags_s clr_bits,
    input wire cset_pkg::cset_flags_s mask,
    output cset_pkg::cset_flags_s status,
    output logic irq
);
    logic [cset_pkg::NUM_FLAGS-1:0] status_q;
    logic [cset_pkg::NUM_FLAGS-1:0] status_d;

    // ----------------------------------------
    // Sticky flags, set beats clear
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < cset_pkg::NUM_FLAGS; i++) begin : g_flag
            always_comb begin
                status_d[i] = set_ev[i] | (status_q[i] & ~(clr_we & clr_bits[i]));
            end
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_q <= '0;
        end else begin
            status_q <= status_d;
        end
    end

    assign status = status_q;
    assign irq = |(status_q & mask);
endmodule

// ---- core/cset_top.sv ----
// The placing of the registers and the Wishbone slave port are this design's own decisions.
`timescale 1ns/100ps
module cset_top (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic adc_enabled,
    output logic adc_start,
    output logic special_event,
    output logic [15:0] timer_count,
    output logic compare_output_pin_o,
    output logic compare_output_pin_oe,
    output logic irq
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic mode_drives_pin(input cset_pkg::cset_mode_t m);
        return (m == cset_pkg::MODE_TOGGLE) || (m == cset_pkg::MODE_SET) ||
               (m == cset_pkg::MODE_CLEAR);
    endfunction

    function automatic logic mode_compares(input cset_pkg::cset_mode_t m);
        return mode_drives_pin(m) || (m == cset_pkg::MODE_SWINT) ||
               (m == cset_pkg::MODE_TRIGGER);
    endfunction

    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic req, wr_fire;
    logic [31:0] rd_mux;

    cset_pkg::cset_ctrl_s ctrl_q, ctrl_d;
    logic [15:0] cmp_q, cmp_d;
    cset_pkg::cset_flags_s mask_q, mask_d;
    cset_pkg::cset_flags_s status;
    logic [15:0] tmr_q, tmr_d;
    logic [31:0] ctrl_w, cmp_w, tmr_w, mask_w;

    // Write lands on the edge where ack is seen high
    assign req = wb_cyc_i & wb_stb_i;
    assign wr_fire = req & wb_we_i & ack_q;

    always_comb begin
        ctrl_w = lane_merge({27'h0, ctrl_q}, wb_dat_i, wb_sel_i);
        cmp_w = lane_merge({16'h0, cmp_q}, wb_dat_i, wb_sel_i);
        tmr_w = lane_merge({16'h0, tmr_q}, wb_dat_i, wb_sel_i);
        mask_w = lane_merge({30'h0, mask_q}, wb_dat_i, wb_sel_i);
    end

    always_comb begin
        unique case (wb_adr_i)
            cset_pkg::OFS_CTRL: rd_mux = {27'h0, ctrl_q};
            cset_pkg::OFS_COMPARE: rd_mux = {16'h0, cmp_q};
            cset_pkg::OFS_TIMER: rd_mux = {16'h0, tmr_q};
            cset_pkg::OFS_STATUS: rd_mux = {30'h0, status};
            cset_pkg::OFS_MASK: rd_mux = {30'h0, mask_q};
            default: rd_mux = 32'h0;
        endcase
    end

    always_comb begin
        ack_d = req & ~ack_q;
        rdat_d = (req & ~ack_q) ? rd_mux : rdat_q;
        ctrl_d = ctrl_q;
        cmp_d = cmp_q;
        mask_d = mask_q;
        if (wr_fire && wb_adr_i == cset_pkg::OFS_CTRL) begin
            ctrl_d = ctrl_w[4:0];
        end
        if (wr_fire && wb_adr_i == cset_pkg::OFS_COMPARE) begin
            cmp_d = cmp_w[15:0];
        end
        if (wr_fire && wb_adr_i == cset_pkg::OFS_MASK) begin
            mask_d = mask_w[1:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0;
            ctrl_q <= cset_pkg::CTRL_RST;
            cmp_q <= cset_pkg::COMPARE_RST;
            mask_q <= cset_pkg::MASK_RST;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            ctrl_q <= ctrl_d;
            cmp_q <= cmp_d;
            mask_q <= mask_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;

    // ----------------------------------------
    // Compare and period timer
    // ----------------------------------------
    logic match, trig_mode, trig_clear, tmr_wr, ovf_ev;
    logic seen_q, seen_d;
    logic match_rise;

    // Assumes the timer is clocked synchronously by clk_sys
    assign match = mode_compares(ctrl_q.mode) && (tmr_q == cmp_q);
    assign trig_mode = (ctrl_q.mode == cset_pkg::MODE_TRIGGER);
    assign special_event = trig_mode & match;
    // Match re-evaluated at the clearing edge, so a rewrite cancels it
    assign trig_clear = special_event & ctrl_q.timer_en;
    assign tmr_wr = wr_fire && (wb_adr_i == cset_pkg::OFS_TIMER);
    assign match_rise = match & ~seen_q;

    always_comb begin
        tmr_d = tmr_q;
        ovf_ev = 1'b0;
        seen_d = match;
        if (tmr_wr) begin
            tmr_d = tmr_w[15:0];
        end else if (trig_clear) begin
            tmr_d = 16'h0000;
        end else if (ctrl_q.timer_en) begin
            tmr_d = tmr_q + 16'h0001;
            ovf_ev = (tmr_q == 16'hFFFF);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            tmr_q <= cset_pkg::TIMER_RST;
            seen_q <= 1'b0;
        end else begin
            tmr_q <= tmr_d;
            seen_q <= seen_d;
        end
    end

    assign timer_count = tmr_q;
    // One pulse per match, even while the timer is stopped on it
    assign adc_start = special_event & adc_enabled & ~seen_q;

    // ----------------------------------------
    // Output pin latch
    // ----------------------------------------
    logic pin_q, pin_d;

    always_comb begin
        pin_d = pin_q;
        if (ctrl_q.mode == cset_pkg::MODE_OFF) begin
            pin_d = 1'b0;
        end else if (match_rise) begin
            unique case (ctrl_q.mode)
                cset_pkg::MODE_SET: pin_d = 1'b1;
                cset_pkg::MODE_CLEAR: pin_d = 1'b0;
                cset_pkg::MODE_TOGGLE: pin_d = ~pin_q;
                default: pin_d = pin_q;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

    assign compare_output_pin_o = pin_q;
    assign compare_output_pin_oe = mode_drives_pin(ctrl_q.mode);

    // ----------------------------------------
    // Flags and interrupt
    // ----------------------------------------
    cset_pkg::cset_flags_s set_ev;

    always_comb begin
        set_ev.match = match_rise;
        set_ev.ovf = ovf_ev;
    end

    cset_irq u_irq (
        .clk_sys(clk_sys),
        .reset(reset),
        .set_ev(set_ev),
        .clr_we(wr_fire && (wb_adr_i == cset_pkg::OFS_STATUS)),
        .clr_bits(wb_dat_i[1:0]),
        .mask(mask_q),
        .status(status),
        .irq(irq)
    );

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    sequence s_trig_edge;
        trig_mode && (tmr_q == cmp_q) && ctrl_q.timer_en && !tmr_wr;
    endsequence

    sequence s_restart;
        (tmr_q == 16'h0000) ##1 (tmr_q == 16'h0001);
    endsequence

    property p_clear;
        s_trig_edge |=> (tmr_q == 16'h0000);
    endproperty
    a_clear: assert property (p_clear) else $error("timer not reset by trigger");

    property p_adc_gate;
        adc_start |-> (special_event && adc_enabled);
    endproperty
    a_adc_gate: assert property (p_adc_gate) else $error("conversion start without cause");

    property p_adc_go;
        ($rose(match) && trig_mode && adc_enabled) |-> adc_start;
    endproperty
    a_adc_go: assert property (p_adc_go) else $error("conversion start missed");

    property p_no_pin;
        trig_mode |-> !compare_output_pin_oe;
    endproperty
    a_no_pin: assert property (p_no_pin) else $error("pin driven in trigger mode");

    property p_now;
        (trig_mode && tmr_q == cmp_q) |-> special_event;
    endproperty
    a_now: assert property (p_now) else $error("trigger late");

    property p_not_early;
        (special_event && tmr_q != 16'h0000) |-> (timer_count == cmp_q);
    endproperty
    a_not_early: assert property (p_not_early) else $error("count cleared too soon");

    property p_period;
        (s_trig_edge ##1 (ctrl_q.timer_en && !tmr_wr && trig_mode && cmp_q > 16'h0001))
            |-> s_restart;
    endproperty
    a_period: assert property (p_period) else $error("period restart wrong");

    property p_no_ovf;
        (trig_clear && !status.ovf && !tmr_wr) |=> !status.ovf;
    endproperty
    a_no_ovf: assert property (p_no_ovf) else $error("overflow flag from trigger");

    property p_hold;
        (ctrl_q.timer_en && !match && !tmr_wr) |=> (tmr_q == $past(tmr_q) + 16'h0001);
    endproperty
    a_hold: assert property (p_hold) else $error("timer reset without match");

    property p_compare;
        (mode_compares(ctrl_q.mode) && tmr_q == cmp_q) |-> match;
    endproperty
    a_compare: assert property (p_compare) else $error("match missed");

    property p_flag;
        (match && !seen_q) |=> status.match;
    endproperty
    a_flag: assert property (p_flag) else $error("match flag not set");

    property p_once;
        adc_start |=> !adc_start;
    endproperty
    a_once: assert property (p_once) else $error("conversion start held");
endmodule

// ---- tb/cset_adc_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Converter start model
// ----------------------------------------
module cset_adc_model (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic power_on,
    input wire logic adc_start,
    output logic adc_enabled,
    output logic [7:0] start_count
);
    assign adc_enabled = power_on;
    // Counts every start, even when off, so stray ones show
    always_ff @(posedge clk_sys) begin // Same clock as the timer
        if (reset) begin
            start_count <= 8'h00;
        end else if (adc_start) begin
            start_count <= start_count + 8'h01;
        end
    end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
module tb_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, r;
    logic wb_ack_o, adc_enabled, adc_start, special_event, pin_o, pin_oe, irq;
    logic power_on = 1'b0;
    logic [15:0] timer_count, cmp;
    logic [7:0] starts, s0;
    int err_count = 0;
    int checks = 0;
    int n, seed;
    logic [7:0] adr_tab [6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [31:0] rst_tab [6] = '{32'h0, 32'hFFFF, 32'h0, 32'h0, 32'h0, 32'h0};

    always #20 clk_sys = ~clk_sys;

    cset_top i_dut (.clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .adc_enabled(adc_enabled), .adc_start(adc_start),
        .special_event(special_event), .timer_count(timer_count), .compare_output_pin_o(pin_o),
        .compare_output_pin_oe(pin_oe), .irq(irq));
    cset_adc_model i_adc (.clk_sys(clk_sys), .reset(reset), .power_on(power_on),
        .adc_start(adc_start), .adc_enabled(adc_enabled), .start_count(starts));

    // ----------------------------------------
    // Bus, compare and closing tasks
    // ----------------------------------------
    task automatic xfer(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'hF;
        wb_dat_i <= d;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        q = wb_dat_o;
        if (k >= 50) begin
            err_count++;
        end
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Bounded wait; sampled values are those of the cycle just ended
    task automatic wait_ev(output int k);
        k = 0;
        do begin
            @(posedge clk_sys);
            k++;
        end while (special_event !== 1'b1 && k < 2000);
        if (special_event !== 1'b1) begin
            err_count++;
        end
    endtask

    // Moves the compare away and back, so the held match rises again
    task automatic rematch;
        wr(cset_pkg::OFS_COMPARE, 32'h6);
        wr(cset_pkg::OFS_COMPARE, 32'h5);
        @(posedge clk_sys);
    endtask

    function automatic int exp_period(input logic [15:0] c);
        return int'(c) + 1;
    endfunction

    function automatic logic [31:0] ctrl_val(input logic en, input cset_pkg::cset_mode_t m);
        return {27'h0, en, m};
    endfunction

    task automatic test_done;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        test_done();
    end

    initial begin
        seed = $urandom(32'hD3C4);
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        for (int i = 0; i < 6; i++) begin
            rd(adr_tab[i], r);
            chk("reset value", rst_tab[i], r);
        end
        power_on <= 1'b1;
        wr(cset_pkg::OFS_MASK, 32'h1);
        for (int k = 0; k < 4; k++) begin
            // Smallest period first, where clear and match are closest
            cmp = (k == 0) ? 16'h0001 : 16'($urandom_range(40, 2));
            wr(cset_pkg::OFS_CTRL, 32'h0);
            wr(cset_pkg::OFS_TIMER, 32'h0);
            wr(cset_pkg::OFS_COMPARE, {16'h0, cmp});
            wr(cset_pkg::OFS_STATUS, 32'h3);
            s0 = starts;
            wr(cset_pkg::OFS_CTRL, ctrl_val(1'b1, cset_pkg::MODE_TRIGGER));
            wait_ev(n);
            chk("timer at match", {16'h0, cmp}, {16'h0, timer_count});
            chk("adc start", 32'h1, {31'h0, adc_start});
            chk("pin enable", 32'h0, {31'h0, pin_oe});
            @(posedge clk_sys);
            chk("timer cleared", 32'h0, {16'h0, timer_count});
            chk("start pulse", 32'h0, {31'h0, adc_start});
            wait_ev(n);
            chk("period", exp_period(cmp), n + 1);
            chk("start count", 32'(s0) + 1, {24'h0, starts});
            chk("adc start again", 32'h1, {31'h0, adc_start});
            rd(cset_pkg::OFS_STATUS, r);
            chk("status flags", 32'h1, r);
            chk("irq", 32'h1, {31'h0, irq});
        end
        power_on <= 1'b0;
        @(posedge clk_sys);
        s0 = starts;
        wait_ev(n);
        chk("event while off", 32'h1, {31'h0, special_event});
        chk("adc start off", 32'h0, {31'h0, adc_start});
        @(posedge clk_sys);
        chk("adc off start", 32'(s0), {24'h0, starts});
        wr(cset_pkg::OFS_CTRL, 32'h0);
        wr(cset_pkg::OFS_STATUS, 32'h3);
        chk("irq cleared", 32'h0, {31'h0, irq});
        // Stopped timer holds the match across many cycles
        power_on <= 1'b1;
        s0 = starts;
        wr(cset_pkg::OFS_COMPARE, 32'h20);
        wr(cset_pkg::OFS_TIMER, 32'h20);
        wr(cset_pkg::OFS_CTRL, ctrl_val(1'b0, cset_pkg::MODE_TRIGGER));
        repeat (8) @(posedge clk_sys);
        chk("held event", 32'h1, {31'h0, special_event});
        chk("held timer", 32'h20, {16'h0, timer_count});
        chk("held starts", 32'(s0) + 1, {24'h0, starts});
        wr(cset_pkg::OFS_COMPARE, 32'h30);
        wr(cset_pkg::OFS_CTRL, ctrl_val(1'b1, cset_pkg::MODE_TRIGGER));
        @(posedge clk_sys);
        chk("no clear", 32'h21, {16'h0, timer_count});
        // Natural overflow still flags, masked path to irq
        wr(cset_pkg::OFS_CTRL, 32'h0);
        wr(cset_pkg::OFS_STATUS, 32'h3);
        wr(cset_pkg::OFS_MASK, 32'h2);
        wr(cset_pkg::OFS_TIMER, 32'hFFFE);
        wr(cset_pkg::OFS_CTRL, ctrl_val(1'b1, cset_pkg::MODE_OFF));
        repeat (4) @(posedge clk_sys);
        rd(cset_pkg::OFS_STATUS, r);
        chk("overflow flag", 32'h2, r & 32'h2);
        chk("irq overflow", 32'h1, {31'h0, irq});
        wr(cset_pkg::OFS_MASK, 32'h0);
        chk("irq masked", 32'h0, {31'h0, irq});
        // Pin modes on a stopped timer; latch changes only on a new match, and clears when the mode is off
        s0 = starts;
        wr(cset_pkg::OFS_CTRL, 32'h0);
        wr(cset_pkg::OFS_TIMER, 32'h5);
        wr(cset_pkg::OFS_COMPARE, 32'h5);
        wr(cset_pkg::OFS_CTRL, ctrl_val(1'b0, cset_pkg::MODE_SET));
        @(posedge clk_sys);
        chk("pin set", 32'h1, {31'h0, pin_o});
        chk("pin enable set mode", 32'h1, {31'h0, pin_oe});
        chk("no event set mode", 32'h0, {31'h0, special_event});
        rd(cset_pkg::OFS_STATUS, r);
        chk("match flag set mode", 32'h1, r & 32'h1);
        wr(cset_pkg::OFS_CTRL, ctrl_val(1'b0, cset_pkg::MODE_CLEAR));
        rematch();
        chk("pin clear", 32'h0, {31'h0, pin_o});
        wr(cset_pkg::OFS_CTRL, ctrl_val(1'b0, cset_pkg::MODE_TOGGLE));
        rematch();
        chk("pin toggle", 32'h1, {31'h0, pin_o});
        wr(cset_pkg::OFS_CTRL, ctrl_val(1'b0, cset_pkg::MODE_SWINT));
        wr(cset_pkg::OFS_STATUS, 32'h3);
        rematch();
        rd(cset_pkg::OFS_STATUS, r);
        chk("match flag swint", 32'h1, r);
        chk("pin enable swint", 32'h0, {31'h0, pin_oe});
        wr(cset_pkg::OFS_CTRL, 32'h0);
        @(posedge clk_sys);
        chk("pin off", 32'h0, {31'h0, pin_o});
        chk("pin mode starts", 32'(s0), {24'h0, starts});
        test_done();
    end
endmodule
